//--- rtc_consts.svh
// Constants for the real-time clock: ports, indices, bit fields, timing.
// Assumes inclusion by rtc_host_port, rtc_core and the bench.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define PORT_B0_INDEX   16'h0070
`define PORT_B0_DATA    16'h0071
`define IDX_SECONDS     7'h00
`define IDX_YEAR        7'h09
`define IDX_REG_A       7'h0A
`define IDX_REG_B       7'h0B
`define IDX_REG_C       7'h0C
`define IDX_REG_D       7'h0D
`define IDX_CENTURY     7'h7D
`define B_SET           7
`define B_PIE           6
`define B_AIE           5
`define B_UIE           4
`define B_DM            2
`define B_H24           1
`define C_REQUEST_SUMMARY_FLAG          7
`define C_PF            6
`define C_AF            5
`define C_UF            4
`define DIV_RUN         3'h2
`define DIV_HALF        15'h4000
`define DIV_LAST        15'h7FFF
`define CRYSTAL_HZ      32768
`define UIP_LEAD_US     244
`define UIP_LEAD_TICKS  ((`UIP_LEAD_US * `CRYSTAL_HZ + 999999) / 1000000)
`define IRQ_LINE_8      4'h8
`define WILDCARD_TOP    2'h3

`endif

//--- rtc_pkg.sv
// Types shared by the real-time clock host port and core.
// Assumes rtc_consts.svh is on the include path.
`default_nettype none

package rtc_pkg;
	typedef enum logic [2:0] {
		PORT_NONE     = 3'b000,
		PORT_B0_INDEX = 3'b001,
		PORT_B0_DATA  = 3'b010,
		PORT_B1_INDEX = 3'b011,
		PORT_B1_DATA  = 3'b100
	} port_sel_t;

	typedef struct packed {
		logic      valid;
		logic      write;
		port_sel_t sel;
		logic [7:0] data;
	} host_req_t;
endpackage

`default_nettype wire

//--- rtc_host_port.sv
// Host I/O port: synchronises the bus pins and decodes the four ports.
// Assumes the strobes stay low for several clk cycles per access.
`default_nettype none
`include "rtc_consts.svh"

module rtc_host_port (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Bus pins
	input  wire logic [15:0]       io_addr,
	input  wire logic [7:0]        io_data_in,
	input  wire logic              io_rd_n,
	input  wire logic              io_wr_n,
	input  wire logic              aen,
	// Relocatable bank 1 base
	input  wire logic [15:0]       bank1_base,
	// Decoded request
	output var rtc_pkg::host_req_t req,
	output logic                   rd_active
);
	import rtc_pkg::*;

	logic [15:0] addr_s1_q, addr_s2_q;
	logic [7:0]  data_s1_q, data_s2_q;
	logic [2:0]  ctl_s1_q, ctl_s2_q, ctl_s3_q;
	port_sel_t   sel;
	logic        rd_fall, wr_rise;

	// All pins pass two flops before any decode reads them.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			addr_s1_q <= 16'h0000;
			addr_s2_q <= 16'h0000;
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
			ctl_s1_q  <= 3'h3;
			ctl_s2_q  <= 3'h3;
			ctl_s3_q  <= 3'h3;
		end else begin
			addr_s1_q <= io_addr;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= io_data_in;
			data_s2_q <= data_s1_q;
			ctl_s1_q  <= {aen, io_rd_n, io_wr_n};
			ctl_s2_q  <= ctl_s1_q;
			ctl_s3_q  <= ctl_s2_q;
		end
	end

	always_comb begin
		sel = PORT_NONE;
		if (ctl_s2_q[2]) begin
			sel = PORT_NONE;
		end else if (addr_s2_q == `PORT_B0_INDEX) begin
			sel = PORT_B0_INDEX;
		end else if (addr_s2_q == `PORT_B0_DATA) begin
			sel = PORT_B0_DATA;
		end else if (addr_s2_q == bank1_base) begin
			sel = PORT_B1_INDEX;
		end else if (addr_s2_q == bank1_base + 16'h0001) begin
			sel = PORT_B1_DATA;
		end
	end

	// Reads act at the strobe's start, writes at its end when data is firm.
	assign rd_fall = ctl_s3_q[1] && !ctl_s2_q[1];
	assign wr_rise = !ctl_s3_q[0] && ctl_s2_q[0];
	assign rd_active = !ctl_s2_q[1];

	always_comb begin
		req.valid = (rd_fall || wr_rise) && (sel != PORT_NONE);
		req.write = wr_rise;
		req.sel   = sel;
		req.data  = data_s2_q;
	end
endmodule

`default_nettype wire

//--- rtc_core.sv
// Real-time clock core: calendar, alarm, flags and two CMOS banks.
// Assumes rtc_host_port timing; crystal and reset pins are asynchronous.
`default_nettype none
`include "rtc_consts.svh"

// Notes on behaviour
// - Bank 0 index at 0x70, data at 0x71, only when AEN allows.
// - Index write selects a location; data port reads or writes it.
// - Bank 1 index at the base, data at base plus one, 128 bytes.
// - Timekeeping advances only on 32.768 kHz crystal edges.
// - System reset with good battery leaves time, calendar and RAM untouched.
// - Reset with good battery clears enables, flags, access, irq drive.
// - Reset with low battery zeroes locations 00 to 0D, blocks access.
// - Interrupt is high while any enabled source flag is set.
// - Reading register C or system reset drops the interrupt.
// - Interrupt drives a line only for non-zero select; line 8 polarity.
// - Bank 0 map: time, alarms, A-D, RAM, century 7D.
// - Register C, A bit 7, D bit 7, B bit 0 are read-only.
// - While the update inhibit bit is set, no time updates happen.
// - Format bit picks binary or BCD counting of all time bytes.
// - Hour format picks 1-12 with PM bit 7, or 0-23.
// - Each second the time advances by one and the alarm is checked.
// - Month lengths and leap days are handled automatically.
// - Matching seconds, minutes, hours and date raise the alarm flag.
// - Alarm bytes C0 to FF match any value.
// - Counters wrap at their documented ranges in both formats.
// - Year carries into century, reaching year 9999.
// - Register D holds date alarm low and battery-valid bit 7.
// - Update-pending rises 244 us before each update.
// - Rate select picks one of 13 periodic taps or none.
// - Releasing the divider reset gives the first update half a second on.
module rtc_core (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Host I/O bus
	input  wire logic [15:0] io_addr,
	input  wire logic [7:0]  io_data_in,
	input  wire logic        io_rd_n,
	input  wire logic        io_wr_n,
	input  wire logic        aen,
	output logic      [7:0]  io_data_out,
	output logic             io_data_oe,
	// Configuration
	input  wire logic [7:0]  bank1_base_low_cfg,
	input  wire logic [7:0]  bank1_base_high_cfg,
	input  wire logic [3:0]  irq_select,
	input  wire logic        irq8_invert,
	// System pins
	input  wire logic        system_reset_in,
	input  wire logic        battery_good,
	input  wire logic        crystal_in,
	output logic             crystal_out,
	// Interrupt pin
	output logic             interrupt_out,
	output logic             interrupt_oe
);
	import rtc_pkg::*;

	host_req_t  req;
	logic       rd_active;
	logic [7:0] tm_q [0:9];
	logic [7:0] nxt [0:9];
	logic [7:0] cent_q, nxt_cent;
	logic [7:0] mem0 [0:127];
	logic [7:0] mem1 [0:127];
	logic [6:0] idx0_q, idx1_q, d_q;
	logic [6:0] a_q;
	logic [7:0] b_q, rdata;
	logic [3:0] flags_q;
	logic       uip_q, upd, upd_d1_q, run, tick, per_hit, alarm_hit;
	logic [1:0] rst_s_q, bat_s_q;
	logic [2:0] xtal_q;
	logic [14:0] div_q;
	logic [3:0] uip_ticks_q;
	logic       sys_rst, low_bat, host_ok, wr0, rd_c, irq_raw;
	logic [2:0] ev;

	rtc_host_port u_port (
		.clk       (clk),
		.reset_n   (reset_n),
		.io_addr   (io_addr),
		.io_data_in(io_data_in),
		.io_rd_n   (io_rd_n),
		.io_wr_n   (io_wr_n),
		.aen       (aen),
		.bank1_base({bank1_base_high_cfg, bank1_base_low_cfg}),
		.req       (req),
		.rd_active (rd_active)
	);

	function automatic logic [7:0] from_fmt(input logic [7:0] v,
		input logic bin);
		from_fmt = bin ? v : 8'({4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]});
	endfunction

	function automatic logic [7:0] to_fmt(input logic [7:0] n,
		input logic bin);
		logic [7:0] q, r;
		q = n / 8'h0A;
		r = n % 8'h0A;
		to_fmt = bin ? n : {q[3:0], r[3:0]};
	endfunction

	function automatic logic [7:0] month_days(input logic [7:0] m,
		input logic [7:0] y, input logic [7:0] c);
		logic leap;
		leap = (y[1:0] == 2'h0) && (y != 8'h00 || c[1:0] == 2'h0);
		if (m == 8'h02) begin
			month_days = leap ? 8'h1D : 8'h1C;
		end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0B) begin
			month_days = 8'h1E;
		end else begin
			month_days = 8'h1F;
		end
	endfunction

	function automatic logic alarm_ok(input logic [7:0] al,
		input logic [7:0] t);
		alarm_ok = (al[7:6] == `WILDCARD_TOP) || (al == t);
	endfunction

	// Pins from outside the clock domain pass two flops first.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rst_s_q <= 2'h0;
			bat_s_q <= 2'h0;
			xtal_q  <= 3'h0;
		end else begin
			rst_s_q <= {rst_s_q[0], system_reset_in};
			bat_s_q <= {bat_s_q[0], battery_good};
			xtal_q  <= {xtal_q[1:0], crystal_in};
		end
	end

	assign sys_rst = rst_s_q[1];
	assign low_bat = sys_rst && !bat_s_q[1];
	assign tick    = xtal_q[1] && !xtal_q[2];
	assign crystal_out = ~xtal_q[2];
	assign host_ok = req.valid && !sys_rst;
	assign wr0     = host_ok && req.write && req.sel == PORT_B0_DATA;
	assign rd_c    = host_ok && !req.write && req.sel == PORT_B0_DATA
		&& idx0_q == `IDX_REG_C;
	assign run     = a_q[6:4] == `DIV_RUN;

	// Divider chain; held at the half-second point while in reset.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div_q <= `DIV_HALF;
		end else if (!run) begin
			div_q <= `DIV_HALF;
		end else if (tick) begin
			div_q <= div_q + 15'h0001;
		end
	end

	assign upd = tick && run && uip_q && !b_q[`B_SET]
		&& div_q == `DIV_LAST;

	// Update-pending leads each update by a fixed count of crystal ticks.
	always_ff @(posedge clk) begin
		if (!reset_n || !run || b_q[`B_SET] || upd_d1_q) begin
			uip_q <= 1'b0;
		end else if (tick && div_q == 15'(`DIV_LAST - `UIP_LEAD_TICKS)) begin
			uip_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			upd_d1_q <= 1'b0;
		end else begin
			upd_d1_q <= upd;
		end
	end

	always_comb begin
		logic       bin, cy, pm;
		logic [7:0] v, h, md, hf;
		bin = b_q[`B_DM];
		cy  = 1'b0;
		pm  = 1'b0;
		v   = 8'h00;
		h   = 8'h00;
		md  = 8'h00;
		hf  = 8'h00;
		for (int i = 0; i < 10; i++) begin
			nxt[i] = tm_q[i];
		end
		nxt_cent = cent_q;
		v = from_fmt(tm_q[0], bin);
		cy = v >= 8'h3B;
		nxt[0] = to_fmt(cy ? 8'h00 : v + 8'h01, bin);
		if (cy) begin
			v = from_fmt(tm_q[2], bin);
			cy = v >= 8'h3B;
			nxt[2] = to_fmt(cy ? 8'h00 : v + 8'h01, bin);
		end
		if (cy) begin
			pm = tm_q[4][7];
			h = from_fmt({1'b0, tm_q[4][6:0]}, bin);
			if (b_q[`B_H24]) begin
				cy = h >= 8'h17;
				nxt[4] = to_fmt(cy ? 8'h00 : h + 8'h01, bin);
			end else begin
				cy = (h == 8'h0B) && pm;
				if (h == 8'h0B) begin
					pm = !pm;
				end
				h = (h >= 8'h0C) ? 8'h01 : h + 8'h01;
				hf = to_fmt(h, bin);
				nxt[4] = {pm, hf[6:0]};
			end
		end
		if (cy) begin
			v = from_fmt(tm_q[6], bin);
			nxt[6] = to_fmt((v >= 8'h07) ? 8'h01 : v + 8'h01, bin);
			md = month_days(from_fmt(tm_q[8], bin),
				from_fmt(tm_q[9], bin), from_fmt(cent_q, bin));
			v = from_fmt(tm_q[7], bin);
			cy = v >= md;
			nxt[7] = to_fmt(cy ? 8'h01 : v + 8'h01, bin);
		end
		if (cy) begin
			v = from_fmt(tm_q[8], bin);
			cy = v >= 8'h0C;
			nxt[8] = to_fmt(cy ? 8'h01 : v + 8'h01, bin);
		end
		if (cy) begin
			v = from_fmt(tm_q[9], bin);
			cy = v >= 8'h63;
			nxt[9] = to_fmt(cy ? 8'h00 : v + 8'h01, bin);
		end
		if (cy) begin
			v = from_fmt(cent_q, bin);
			nxt_cent = to_fmt((v >= 8'h63) ? 8'h00 : v + 8'h01, bin);
		end
	end

	// Time bytes: advanced by the update, loaded by the host.
	always_ff @(posedge clk) begin
		if (!reset_n || low_bat) begin
			for (int i = 0; i < 10; i++) begin
				tm_q[i] <= 8'h00;
			end
			cent_q <= 8'h00;
		end else if (upd) begin
			for (int i = 0; i < 10; i++) begin
				tm_q[i] <= nxt[i];
			end
			cent_q <= nxt_cent;
		end else if (wr0 && idx0_q <= `IDX_YEAR) begin
			tm_q[idx0_q[3:0]] <= req.data;
		end else if (wr0 && idx0_q == `IDX_CENTURY) begin
			cent_q <= req.data;
		end
	end

	// Control registers A, B and D; read-only bits are never stored.
	always_ff @(posedge clk) begin
		if (!reset_n || low_bat) begin
			a_q <= 7'h00;
			b_q <= 8'h00;
			d_q <= 7'h00;
		end else begin
			if (sys_rst) begin
				b_q[`B_PIE:`B_UIE] <= 3'h0;
			end
			if (wr0 && idx0_q == `IDX_REG_A) begin
				a_q <= req.data[6:0];
			end
			if (wr0 && idx0_q == `IDX_REG_B) begin
				b_q <= {req.data[7:1], 1'b0};
			end
			if (wr0 && idx0_q == `IDX_REG_D) begin
				d_q <= req.data[6:0];
			end
		end
	end

	// Index registers; both keep seven bits, so bank 1 wraps.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			idx0_q <= 7'h00;
			idx1_q <= 7'h00;
		end else if (host_ok && req.write) begin
			if (req.sel == PORT_B0_INDEX) begin
				idx0_q <= req.data[6:0];
			end else if (req.sel == PORT_B1_INDEX) begin
				idx1_q <= req.data[6:0];
			end
		end
	end

	// Plain CMOS bytes; no reset touches them.
	always_ff @(posedge clk) begin
		if (wr0 && idx0_q > `IDX_REG_D && idx0_q != `IDX_CENTURY) begin
			mem0[idx0_q] <= req.data;
		end
		if (host_ok && req.write && req.sel == PORT_B1_DATA) begin
			mem1[idx1_q] <= req.data;
		end
	end

	// Periodic tap: codes 1 and 2 reuse the taps of codes 8 and 9.
	always_comb begin
		logic [3:0] n;
		n = (a_q[3:0] < 4'h3) ? a_q[3:0] + 4'h6 : a_q[3:0] - 4'h1;
		per_hit = (a_q[3:0] != 4'h0)
			&& ((div_q & ((15'h0001 << n) - 15'h0001))
			== ((15'h0001 << n) - 15'h0001));
	end

	assign alarm_hit = alarm_ok(tm_q[1], tm_q[0])
		&& alarm_ok(tm_q[3], tm_q[2]) && alarm_ok(tm_q[5], tm_q[4])
		&& (d_q[5:0] == 6'h00 || {2'h0, d_q[5:0]} == tm_q[7]);

	// Flags {pf, af, uf, request_summary_flag}: a new event wins over a C read.
	assign ev = {tick && run && per_hit, upd_d1_q && alarm_hit, upd_d1_q};

	always_ff @(posedge clk) begin
		if (!reset_n || sys_rst) begin
			flags_q <= 4'h0;
		end else begin
			flags_q[3:1] <= ev | (rd_c ? 3'h0 : flags_q[3:1]);
			flags_q[0]   <= |(ev & b_q[`B_PIE:`B_UIE])
				|| (flags_q[0] && !rd_c);
		end
	end

	assign irq_raw = |(flags_q[3:1] & b_q[`B_PIE:`B_UIE]);

	always_ff @(posedge clk) begin
		if (!reset_n || sys_rst) begin
			interrupt_out <= 1'b0;
			interrupt_oe  <= 1'b0;
		end else begin
			interrupt_oe  <= irq_select != 4'h0;
			interrupt_out <= irq_raw
				^ (irq8_invert && irq_select == `IRQ_LINE_8);
		end
	end

	always_comb begin
		rdata = 8'h00;
		if (req.sel == PORT_B0_INDEX) begin
			rdata = {1'b0, idx0_q};
		end else if (req.sel == PORT_B1_INDEX) begin
			rdata = {1'b0, idx1_q};
		end else if (req.sel == PORT_B1_DATA) begin
			rdata = mem1[idx1_q];
		end else if (idx0_q <= `IDX_YEAR) begin
			rdata = tm_q[idx0_q[3:0]];
		end else if (idx0_q == `IDX_REG_A) begin
			rdata = {uip_q, a_q};
		end else if (idx0_q == `IDX_REG_B) begin
			rdata = b_q;
		end else if (idx0_q == `IDX_REG_C) begin
			rdata = {flags_q[0], flags_q[3:1], 4'h0};
		end else if (idx0_q == `IDX_REG_D) begin
			rdata = {bat_s_q[1], d_q};
		end else if (idx0_q == `IDX_CENTURY) begin
			rdata = cent_q;
		end else begin
			rdata = mem0[idx0_q];
		end
	end

	// Read data is held and driven until the host lifts its strobe.
	always_ff @(posedge clk) begin
		if (!reset_n || !rd_active || sys_rst) begin
			io_data_oe  <= 1'b0;
			io_data_out <= 8'h00;
		end else if (host_ok && !req.write) begin
			io_data_oe  <= 1'b1;
			io_data_out <= rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n || !uip_q) begin
			uip_ticks_q <= 4'h0;
		end else if (tick && uip_ticks_q != 4'hF) begin
			uip_ticks_q <= uip_ticks_q + 4'h1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_uip_lead:
	assert property (upd |-> uip_ticks_q == 4'(`UIP_LEAD_TICKS - 1))
	else $error("update did not follow the pending lead");
	a_irq_route:
	assert property (irq_select == 4'h0 && !sys_rst |=> !interrupt_oe)
	else $error("interrupt driven with no line selected");
	a_reset_float:
	assert property (sys_rst |=> !interrupt_oe && flags_q == 4'h0)
	else $error("reset left interrupt or flags active");
	a_lowbat_zero:
	assert property (low_bat |=> tm_q[0] == 8'h00 && b_q == 8'h00)
	else $error("low battery reset did not zero time");
	a_set_freeze:
	assert property (b_q[`B_SET] && !wr0 |=> $stable(tm_q[0]))
	else $error("seconds moved while updates inhibited");
	a_c_clear:
	assert property (rd_c && !tick && !upd_d1_q |=> flags_q == 4'h0)
	else $error("register C read did not clear flags");
	a_irq_level:
	assert property (irq_raw && irq_select == 4'h1 && !sys_rst
		|=> interrupt_out)
	else $error("enabled flag did not raise interrupt");
	a_sec_wrap:
	assert property (upd && tm_q[0] == to_fmt(8'h3B, b_q[`B_DM])
		|=> tm_q[0] == 8'h00)
	else $error("seconds did not wrap to zero");
	a_no_access:
	assert property (sys_rst |=> !io_data_oe)
	else $error("host read answered during reset");

	c_update: cover property (upd ##[1:4] flags_q[1]);
	c_alarm: cover property (upd_d1_q && alarm_hit);
	c_c_read: cover property (rd_c && flags_q[0]);
endmodule

`default_nettype wire

//--- isa_host_model.sv
// Host bus model: runs port read and write cycles on the ISA pins.
// Assumes the bench calls its tasks and leaves these pins alone.
`default_nettype none

module isa_host_model (
	// Clock
	input  wire logic        clk,
	// Bus pins
	output logic      [15:0] io_addr,
	output logic      [7:0]  io_data_in,
	output logic             io_rd_n,
	output logic             io_wr_n,
	output logic             aen,
	input  wire logic [7:0]  io_data_out,
	input  wire logic        io_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		io_addr = 16'h0000;
		io_data_in = 8'h00;
		io_rd_n = 1'b1;
		io_wr_n = 1'b1;
		aen = 1'b1;
	end

	// Write strobes stay four cycles low, reads eight, and at least four high, so the
	// design's input synchronisers never miss or merge a cycle.
	task automatic io_write(input logic [15:0] a, input logic [7:0] d,
			input logic q);
		@(negedge clk);
		io_addr = a;
		aen = q;
		io_data_in = d;
		io_wr_n = 1'b0;
		repeat (4) @(negedge clk);
		io_wr_n = 1'b1;
		repeat (4) @(negedge clk);
		aen = 1'b1;
		// A released bus must not keep showing the old byte.
		io_data_in = ~d;
	endtask

	task automatic io_read(input logic [15:0] a, input logic q,
			output logic [7:0] rd, output logic oe);
		@(negedge clk);
		io_addr = a;
		aen = q;
		io_rd_n = 1'b0;
		repeat (8) @(negedge clk);
		rd = io_data_out;
		oe = io_data_oe;
		io_rd_n = 1'b1;
		repeat (4) @(negedge clk);
		aen = 1'b1;
	endtask
endmodule

`default_nettype wire

//--- test_cmos_rtc_with_host_port.sv
// Self-checking bench for the clock core through its host ports.
// Assumes rtc_consts.svh on the include path and isa_host_model.
`default_nettype none
`include "rtc_consts.svh"
`define CHECK(got, exp) begin num_checks++; \
	if ((got) !== (exp)) begin fail_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module test_cmos_rtc_with_host_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] B0 = `PORT_B0_INDEX;
	localparam logic [15:0] B1 = 16'h0300;

	logic        clk, reset_n, io_rd_n, io_wr_n, aen;
	logic [15:0] io_addr;
	logic [7:0]  io_data_in, io_data_out;
	logic        io_data_oe, crystal_out, interrupt_out, interrupt_oe;
	logic [3:0]  irq_select;
	logic        irq8_invert, system_reset_in, battery_good, crystal_in;
	int          fail_count = 0;
	int          num_checks = 0;

	isa_host_model host_u (.clk(clk), .io_addr(io_addr),
		.io_data_in(io_data_in), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
		.aen(aen), .io_data_out(io_data_out), .io_data_oe(io_data_oe));

	rtc_core dut_u (.clk(clk), .reset_n(reset_n), .io_addr(io_addr),
		.io_data_in(io_data_in), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
		.aen(aen), .io_data_out(io_data_out), .io_data_oe(io_data_oe),
		.bank1_base_low_cfg(B1[7:0]), .bank1_base_high_cfg(B1[15:8]),
		.irq_select(irq_select), .irq8_invert(irq8_invert),
		.system_reset_in(system_reset_in), .battery_good(battery_good),
		.crystal_in(crystal_in), .crystal_out(crystal_out),
		.interrupt_out(interrupt_out), .interrupt_oe(interrupt_oe));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr_reg(input logic [15:0] p, input logic [6:0] i,
			input logic [7:0] d);
		host_u.io_write(p, {1'b0, i}, 1'b0);
		host_u.io_write(p + 16'h0001, d, 1'b0);
	endtask

	task automatic chk_reg(input logic [15:0] p, input logic [6:0] i,
			input logic [7:0] e);
		logic [7:0] r;
		logic       oe;
		host_u.io_write(p, {1'b0, i}, 1'b0);
		host_u.io_read(p + 16'h0001, 1'b0, r, oe);
		`CHECK(oe, 1'b1)
		`CHECK(r, e)
	endtask

	// Crystal idles low and runs only while ticks are asked for, apart from the one pulse in test_ram.
	// Two clocks per tick keep both half-second runs inside the budget.
	task automatic ticks(input int n);
		repeat (n) begin
			crystal_in = 1'b1;
			@(negedge clk);
			crystal_in = 1'b0;
			@(negedge clk);
		end
	endtask

	task automatic test_ram();
		logic [7:0] r;
		logic       oe;
		crystal_in = 1'b1;
		repeat (4) @(negedge clk);
		`CHECK(crystal_out, 1'b0)
		crystal_in = 1'b0;
		wr_reg(B0, 7'h0E, 8'h5A);
		wr_reg(B0, 7'h7F, 8'hA5);
		host_u.io_write(B0 + 16'h0001, 8'hFF, 1'b1);
		host_u.io_read(B0 + 16'h0001, 1'b1, r, oe);
		`CHECK(oe, 1'b0)
		chk_reg(B0, 7'h0E, 8'h5A);
		chk_reg(B0, 7'h7F, 8'hA5);
		$display("test_ram done");
	endtask

	task automatic test_bank1();
		host_u.io_write(B1, 8'h85, 1'b0);
		host_u.io_write(B1 + 16'h0001, 8'h3C, 1'b0);
		chk_reg(B1, 7'h05, 8'h3C);
		wr_reg(B1, 7'h7F, 8'h96);
		chk_reg(B1, 7'h7F, 8'h96);
		chk_reg(B0, 7'h7F, 8'hA5);
		$display("test_bank1 done");
	endtask

	task automatic test_readonly();
		wr_reg(B0, `IDX_REG_A, 8'hFF);
		chk_reg(B0, `IDX_REG_A, 8'h7F);
		wr_reg(B0, `IDX_REG_A, 8'h00);
		wr_reg(B0, `IDX_REG_B, 8'h01);
		chk_reg(B0, `IDX_REG_B, 8'h00);
		wr_reg(B0, `IDX_REG_C, 8'hFF);
		chk_reg(B0, `IDX_REG_C, 8'h00);
		wr_reg(B0, `IDX_REG_D, 8'h1F);
		chk_reg(B0, `IDX_REG_D, 8'h9F);
		$display("test_readonly done");
	endtask

	// Binary, 24 hour: 1999-12-31 23:59:59 must roll into 2000-01-01.
	task automatic test_rollover();
		logic [7:0] init_v [0:9] = '{8'h3B, 8'hFF, 8'h3B, 8'hFF, 8'h17,
			8'hFF, 8'h07, 8'h1F, 8'h0C, 8'h63};
		logic [7:0] next_v [0:9] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00,
			8'hFF, 8'h01, 8'h01, 8'h01, 8'h00};
		wr_reg(B0, `IDX_REG_B, 8'h86);
		for (int i = 0; i < 10; i++)
			wr_reg(B0, 7'(i), init_v[i]);
		wr_reg(B0, `IDX_CENTURY, 8'h13);
		wr_reg(B0, `IDX_REG_D, 8'h01);
		wr_reg(B0, `IDX_REG_B, 8'h36);
		wr_reg(B0, `IDX_REG_A, 8'h20);
		irq_select = 4'h1;
		ticks(16390);
		repeat (4) @(negedge clk);
		`CHECK(interrupt_out, 1'b1)
		`CHECK(interrupt_oe, 1'b1)
		for (int i = 0; i < 10; i++)
			chk_reg(B0, 7'(i), next_v[i]);
		chk_reg(B0, `IDX_CENTURY, 8'h14);
		chk_reg(B0, `IDX_REG_C, 8'hB0);
		`CHECK(interrupt_out, 1'b0)
		chk_reg(B0, `IDX_REG_C, 8'h00);
		irq_select = 4'h8;
		irq8_invert = 1'b1;
		repeat (4) @(negedge clk);
		`CHECK(interrupt_out, 1'b1)
		irq_select = 4'h0;
		irq8_invert = 1'b0;
		repeat (4) @(negedge clk);
		`CHECK(interrupt_oe, 1'b0)
		irq_select = 4'h1;
		$display("test_rollover done");
	endtask

	task automatic test_sysreset();
		logic [7:0] r;
		logic       oe;
		wr_reg(B0, `IDX_REG_A, 8'h23);
		wr_reg(B0, `IDX_REG_B, 8'h46);
		ticks(8);
		repeat (4) @(negedge clk);
		`CHECK(interrupt_out, 1'b1)
		system_reset_in = 1'b1;
		repeat (8) @(negedge clk);
		`CHECK(interrupt_oe, 1'b0)
		host_u.io_read(B0 + 16'h0001, 1'b0, r, oe);
		`CHECK(oe, 1'b0)
		system_reset_in = 1'b0;
		repeat (8) @(negedge clk);
		chk_reg(B0, `IDX_REG_B, 8'h06);
		chk_reg(B0, `IDX_REG_C, 8'h00);
		chk_reg(B0, 7'h08, 8'h01);
		battery_good = 1'b0;
		system_reset_in = 1'b1;
		repeat (8) @(negedge clk);
		host_u.io_read(B0 + 16'h0001, 1'b0, r, oe);
		`CHECK(oe, 1'b0)
		system_reset_in = 1'b0;
		battery_good = 1'b1;
		repeat (8) @(negedge clk);
		for (int i = 0; i < 13; i++)
			chk_reg(B0, 7'(i), 8'h00);
		chk_reg(B0, `IDX_REG_D, 8'h80);
		chk_reg(B0, 7'h0E, 8'h5A);
		$display("test_sysreset done");
	endtask

	// BCD, 12 hour, leap year: 11:59:59 PM on the 28th of February.
	task automatic test_bcd12();
		logic [7:0] init_v [0:9] = '{8'h59, 8'h00, 8'h59, 8'h00, 8'h91,
			8'h12, 8'h07, 8'h28, 8'h02, 8'h24};
		logic [7:0] next_v [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h12,
			8'h12, 8'h01, 8'h29, 8'h02, 8'h24};
		wr_reg(B0, `IDX_REG_B, 8'h80);
		for (int i = 0; i < 10; i++)
			wr_reg(B0, 7'(i), init_v[i]);
		wr_reg(B0, `IDX_CENTURY, 8'h20);
		wr_reg(B0, `IDX_REG_D, 8'h29);
		wr_reg(B0, `IDX_REG_B, 8'h20);
		wr_reg(B0, `IDX_REG_A, 8'h20);
		ticks(16380);
		chk_reg(B0, `IDX_REG_A, 8'hA0);
		ticks(6);
		repeat (4) @(negedge clk);
		`CHECK(interrupt_out, 1'b1)
		chk_reg(B0, `IDX_REG_A, 8'h20);
		for (int i = 0; i < 10; i++)
			chk_reg(B0, 7'(i), next_v[i]);
		chk_reg(B0, `IDX_CENTURY, 8'h20);
		chk_reg(B0, `IDX_REG_C, 8'hB0);
		$display("test_bcd12 done");
	endtask

	initial begin
		// About 90k clocks; the two half-second runs need about 66k.
		#360000;
		fail_count++;
		complete_run();
	end

	initial begin
		reset_n = 1'b0;
		irq_select = 4'h0;
		irq8_invert = 1'b0;
		system_reset_in = 1'b0;
		battery_good = 1'b1;
		crystal_in = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		test_ram();
		test_bank1();
		test_readonly();
		test_rollover();
		test_sysreset();
		test_bcd12();
		complete_run();
	end
endmodule

`default_nettype wire
